// ### dv/sbcb_slave_model.sv
// Purpose: slave network model answering master requests
// Assumes: one request in flight; kind 0 good, 1 timeout, 2 error reply
// Notes:   slave address shows a moving pattern except beside a timeout or error reply, error code except beside an error reply
`timescale 1ns/1ps

module sbcb_slave_model (
  // clock and reset
  input  logic       clk,
  input  logic       sys_rst,
  // request orders from the bench
  input  logic       go,
  input  logic       flood,
  input  logic [1:0] kind,
  input  logic [7:0] slave,
  input  logic [7:0] code,
  input  logic [3:0] delay,
  // events towards the bank, busy towards the bench
  output logic       evt_req_sent,
  output logic       evt_good_reply,
  output logic       evt_timeout,
  output logic       evt_err_reply,
  output logic [7:0] evt_slave_addr,
  output logic [7:0] evt_err_code,
  output logic       busy
);
  logic [3:0] wait_q;
  logic [1:0] kind_q;
  logic [7:0] slave_q;
  logic [7:0] code_q;
  logic [7:0] junk_q = 8'h5a;

  // request pulse first, reply after the chosen wait
  always @(posedge clk) begin
    junk_q         <= junk_q + 8'h35;
    evt_req_sent   <= flood | go;
    evt_good_reply <= 1'b0;
    evt_timeout    <= 1'b0;
    evt_err_reply  <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (go) begin
      busy    <= 1'b1;
      wait_q  <= delay;
      kind_q  <= kind;
      slave_q <= slave;
      code_q  <= code;
    end else if (busy && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy) begin
      busy           <= 1'b0;
      evt_good_reply <= (kind_q == 2'h0);
      evt_timeout    <= (kind_q == 2'h1);
      evt_err_reply  <= (kind_q == 2'h2);
    end
  end

  // fields hold meaning only beside a reply
  assign evt_slave_addr = (evt_timeout | evt_err_reply) ? slave_q : junk_q;
  assign evt_err_code   = evt_err_reply ? code_q : ~junk_q;
endmodule // sbcb_slave_model

// ### dv/sbcb_top_bench.sv
// Purpose: self-checking bench for the serial status and configuration bank
// Assumes: one clock; master events come from the slave network model
// Notes:   the sent counter wrap is reached by flooding request pulses
`timescale 1ns/1ps

module sbcb_top_bench;
  import sbcb_pkg::*;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        s_rx = 1'b0;
  logic        s_tx = 1'b0;
  logic [7:0]  rx_addr = 8'h00;
  logic        go = 1'b0;
  logic        flood = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [7:0]  slave = 8'h00;
  logic [7:0]  code = 8'h00;
  logic [3:0]  delay = 4'h0;
  logic [15:0] reg_rdata;
  logic        req, good, tmo, err, busy, hit, irq, role, moff;
  logic [7:0]  ev_addr, ev_code, f232, b232, f485, b485, saddr;
  logic [15:0] e_sent, e_good, e_tmo, e_err;
  logic [7:0]  e_slv, e_typ, e_code, e_sts;
  logic [7:0]  e_cfg [0:5] = '{8'h00, 8'h03, 8'h00, 8'h03, 8'h01, 8'h00};
  logic [11:0] cfg_a [0:5] = '{SBCB_OFS_RS232_FMT, SBCB_OFS_RS232_BAUD, SBCB_OFS_RS485_FMT,
                               SBCB_OFS_RS485_BAUD, SBCB_OFS_RS485_ADDR, SBCB_OFS_RS485_ROLE};
  logic [31:0] seed = 32'h0000_0018;
  int          mismatches = 0;
  int          total_checks = 0;

  sbcb_top u_sbcb_top (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_req_sent(req),
    .evt_good_reply(good), .evt_timeout(tmo), .evt_err_reply(err),
    .evt_slave_addr(ev_addr), .evt_err_code(ev_code), .evt_slave_rx(s_rx),
    .evt_slave_tx(s_tx), .rx_frame_addr(rx_addr), .rs232_fmt(f232), .rs232_baud(b232),
    .rs485_fmt(f485), .rs485_baud(b485), .rs485_slave_addr(saddr),
    .rs485_master_role(role), .master_off(moff), .slave_addr_hit(hit), .irq(irq));

  sbcb_slave_model u_sbcb_slave_model (
    .clk(clk), .sys_rst(sys_rst), .go(go), .flood(flood), .kind(kind), .slave(slave),
    .code(code), .delay(delay), .evt_req_sent(req), .evt_good_reply(good),
    .evt_timeout(tmo), .evt_err_reply(err), .evt_slave_addr(ev_addr),
    .evt_err_code(ev_code), .busy(busy));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // legal codes of each configuration byte
  function automatic bit ok_val(input int r, input logic [7:0] v);
    case (r)
      0, 2: return v <= 8'h06 && v != 8'h03;
      1, 3: return v <= 8'h06;
      4: return v >= 8'h01 && v <= 8'hf7;
      default: return v <= 8'h01;
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read one register and compare in the cycle after the strobe
  task automatic rc(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "register read");
  endtask

  // one master request and its reply, bounded wait
  task automatic transact(input logic [1:0] k, input logic [7:0] s, input logic [7:0] c,
                          input logic [3:0] dl);
    int n;
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    slave <= s;
    code <= c;
    delay <= dl;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (n = 0; n < 40 && busy === 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, busy}, 16'h0000, "reply wait");
  endtask

  task automatic flood_n(input int n);
    @(posedge clk);
    flood <= 1'b1;
    repeat (n) @(posedge clk);
    flood <= 1'b0;
  endtask

  task automatic slave_ev(input logic rx, input logic tx, input logic [7:0] a, input logic h);
    @(posedge clk);
    s_rx <= rx;
    s_tx <= tx;
    rx_addr <= a;
    @(posedge clk);
    s_rx <= 1'b0;
    s_tx <= 1'b0;
    rx_addr <= ~a;
    #1;
    chk({15'h0000, hit}, {15'h0000, h}, "address hit");
  endtask

  // expected effect of one counted transaction
  task automatic upd(input logic [1:0] k, input logic [7:0] s, input logic [7:0] c);
    e_sent = e_sent + 16'h0001;
    e_good = e_good + {15'h0000, k == 2'h0};
    e_tmo = e_tmo + {15'h0000, k == 2'h1};
    e_err = e_err + {15'h0000, k == 2'h2};
    e_sts = e_sts | 8'h01 | (8'h01 << (k + 2'h1));
    if (k != 2'h0) begin
      e_slv = s;
      e_typ = (k == 2'h1) ? 8'h04 : 8'h05;
      e_code = (k == 2'h1) ? 8'h00 : c;
    end
  endtask

  task automatic zero_exp();
    {e_sent, e_good, e_tmo, e_err} = 64'h0;
    {e_slv, e_typ, e_code} = 24'h0;
  endtask

  task automatic check_master();
    rc(SBCB_OFS_SENT, e_sent);
    rc(SBCB_OFS_GOOD, e_good);
    rc(SBCB_OFS_TIMEOUT, e_tmo);
    rc(SBCB_OFS_ERRREP, e_err);
    rc(SBCB_OFS_LAST_SLAVE, {8'h00, e_slv});
    rc(SBCB_OFS_LAST_TYPE, {8'h00, e_typ});
    rc(SBCB_OFS_LAST_CODE, {8'h00, e_code});
  endtask

  // watchdog well beyond the flood and the random loop
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    int i;
    int j;
    logic [7:0] v;
    logic [7:0] s;
    logic [1:0] k;
    logic [31:0] r;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, reserved and unmapped bytes
    for (i = 0; i < 6; i++) rc(cfg_a[i], {8'h00, e_cfg[i]});
    rc(SBCB_OFS_MASTER, 16'h0001);
    zero_exp();
    check_master();
    wr(SBCB_OFS_RS232_RSVD_B, 16'h00ff);
    wr(SBCB_OFS_MST_RSVD_A, 16'h00ff);
    wr(12'h123, 16'h00ff);
    rc(SBCB_OFS_RS232_RSVD_A, 16'h0000);
    rc(SBCB_OFS_RS232_RSVD_B, 16'h0000);
    rc(SBCB_OFS_MST_RSVD_A, 16'h0000);
    rc(SBCB_OFS_MST_RSVD_B, 16'h0000);
    rc(12'h123, 16'h0000);
    $display("test done: reset values");
    // codes 0 to 9, f7, f8 and one random code of each configuration byte, legal or not
    for (i = 0; i < 6; i++) begin
      for (j = 0; j < 13; j++) begin
        r = rnd();
        v = (j < 10) ? j[7:0] : (j == 10) ? 8'hf7 : (j == 11) ? 8'hf8 : r[7:0];
        wr(cfg_a[i], {8'h00, v});
        if (ok_val(i, v)) e_cfg[i] = v;
        rc(cfg_a[i], {8'h00, e_cfg[i]});
      end
    end
    chk({f232, b232}, {e_cfg[0], e_cfg[1]}, "rs232 setting");
    chk({f485, b485}, {e_cfg[2], e_cfg[3]}, "rs485 setting");
    chk({7'h00, role, saddr}, {7'h00, e_cfg[5][0], e_cfg[4]}, "role");
    $display("test done: configuration");
    // master role, running, interrupt on error replies only
    wr(SBCB_OFS_RS485_ROLE, 16'h0001);
    wr(SBCB_OFS_MASTER, SBCB_CTL_RUN);
    wr(SBCB_OFS_MASTER, 16'h0100);
    rc(SBCB_OFS_MASTER, 16'h0000);
    chk({15'h0000, moff}, 16'h0000, "master off flag");
    wr(SBCB_OFS_IRQ_MASK, 16'h0008);
    wr(SBCB_OFS_IRQ_STS, 16'h003f);
    e_sts = 8'h00;
    slave_ev(1'b1, 1'b1, e_cfg[4], 1'b0);
    rc(SBCB_OFS_SLV_RX, 16'h0000);
    rc(SBCB_OFS_SLV_TX, 16'h0000);
    for (i = 0; i < 24; i++) begin
      r = rnd();
      k = (r[1:0] == 2'h3) ? 2'h2 : r[1:0];
      s = (r[15:8] % 8'hf7) + 8'h01;
      transact(k, s, r[23:16], (i == 0) ? 4'h0 : r[27:24]);
      upd(k, s, r[23:16]);
      check_master();
      rc(SBCB_OFS_IRQ_STS, {8'h00, e_sts});
      chk({15'h0000, irq}, {15'h0000, e_sts[3]}, "interrupt line");
      if (e_sts[3]) begin
        wr(SBCB_OFS_IRQ_STS, 16'h0008);
        e_sts[3] = 1'b0;
        @(posedge clk);
        #1;
        chk({15'h0000, irq}, 16'h0000, "interrupt cleared");
      end
    end
    $display("test done: master traffic");
    // sent counter top value and wrap
    flood_n(65535 - int'(e_sent));
    rc(SBCB_OFS_SENT, 16'hffff);
    flood_n(1);
    rc(SBCB_OFS_SENT, 16'h0000);
    $display("test done: counter wrap");
    // disable clears and freezes, enable counts again
    wr(SBCB_OFS_MASTER, SBCB_CTL_OFF);
    rc(SBCB_OFS_MASTER, 16'h0001);
    zero_exp();
    check_master();
    transact(2'h2, 8'h11, 8'h02, 4'h3);
    check_master();
    wr(SBCB_OFS_MASTER, SBCB_CTL_RUN);
    transact(2'h2, 8'h11, 8'h02, 4'h0);
    upd(2'h2, 8'h11, 8'h02);
    check_master();
    $display("test done: disable");
    // slave role: master reported off, received frames counted by address
    wr(SBCB_OFS_RS485_ROLE, 16'h0000);
    rc(SBCB_OFS_MASTER, 16'h0001);
    zero_exp();
    check_master();
    wr(SBCB_OFS_RS485_ADDR, 16'h002a);
    slave_ev(1'b1, 1'b0, 8'h2a, 1'b1);
    slave_ev(1'b1, 1'b0, 8'h2b, 1'b0);
    slave_ev(1'b0, 1'b1, 8'h2b, 1'b0);
    rc(SBCB_OFS_SLV_RX, 16'h0001);
    rc(SBCB_OFS_SLV_TX, 16'h0001);
    rc(SBCB_OFS_IRQ_STS, {8'h00, e_sts | 8'h30});
    chk({15'h0000, irq}, {15'h0000, e_sts[3]}, "interrupt line");
    $display("test done: slave role");
    give_verdict();
  end
endmodule // sbcb_top_bench

// ### rtl/sbcb_pkg.sv
// Purpose: constants for the serial port status and configuration bank
// Assumes: byte offsets as seen on the plain register port
// Notes:   16-bit registers sit at even offsets, 8-bit ones in the low byte
package sbcb_pkg;

  // register port, byte and counter widths, event count
  localparam int unsigned SBCB_AW = 12;
  localparam int unsigned SBCB_DW = 16;
  localparam int unsigned SBCB_BW = 8;
  localparam int unsigned SBCB_CW = 16;
  localparam int unsigned SBCB_EVN = 6;

  // configuration offsets
  localparam logic [11:0] SBCB_OFS_RS232_RSVD_A = 12'hbf4;
  localparam logic [11:0] SBCB_OFS_RS232_RSVD_B = 12'hbf5;
  localparam logic [11:0] SBCB_OFS_RS232_FMT    = 12'hbf6;
  localparam logic [11:0] SBCB_OFS_RS232_BAUD   = 12'hbf7;
  localparam logic [11:0] SBCB_OFS_RS485_ADDR   = 12'hbfc;
  localparam logic [11:0] SBCB_OFS_RS485_ROLE   = 12'hbfd;
  localparam logic [11:0] SBCB_OFS_RS485_FMT    = 12'hbfe;
  localparam logic [11:0] SBCB_OFS_RS485_BAUD   = 12'hbff;
  // master state (read) and master control (write) share one offset
  localparam logic [11:0] SBCB_OFS_MASTER       = 12'hc1c;
  localparam logic [11:0] SBCB_OFS_MST_RSVD_A   = 12'hc1d;
  localparam logic [11:0] SBCB_OFS_SENT         = 12'hc1e;
  localparam logic [11:0] SBCB_OFS_GOOD         = 12'hc20;
  localparam logic [11:0] SBCB_OFS_TIMEOUT      = 12'hc22;
  localparam logic [11:0] SBCB_OFS_ERRREP       = 12'hc24;
  localparam logic [11:0] SBCB_OFS_LAST_SLAVE   = 12'hc26;
  localparam logic [11:0] SBCB_OFS_LAST_TYPE    = 12'hc27;
  localparam logic [11:0] SBCB_OFS_LAST_CODE    = 12'hc28;
  localparam logic [11:0] SBCB_OFS_MST_RSVD_B   = 12'hc29;
  localparam logic [11:0] SBCB_OFS_SLV_RX       = 12'hc30;
  localparam logic [11:0] SBCB_OFS_SLV_TX       = 12'hc32;
  // interrupt status and mask
  localparam logic [11:0] SBCB_OFS_IRQ_STS      = 12'hc40;
  localparam logic [11:0] SBCB_OFS_IRQ_MASK     = 12'hc42;

  // field values
  localparam logic [7:0]  SBCB_FMT_RESERVED  = 8'h03;
  localparam logic [7:0]  SBCB_FMT_MAX       = 8'h06;
  localparam logic [7:0]  SBCB_BAUD_MAX      = 8'h06;
  localparam logic [7:0]  SBCB_ADDR_MIN      = 8'h01;
  localparam logic [7:0]  SBCB_ADDR_MAX      = 8'hf7;
  localparam logic [7:0]  SBCB_ROLE_SLAVE    = 8'h00;
  localparam logic [7:0]  SBCB_ROLE_MASTER   = 8'h01;
  localparam logic [15:0] SBCB_CTL_RUN       = 16'h0000;
  localparam logic [15:0] SBCB_CTL_OFF       = 16'h0001;
  localparam logic [7:0]  SBCB_STATE_NORMAL  = 8'h00;
  localparam logic [7:0]  SBCB_STATE_OFF     = 8'h01;

  // reset values and counter step
  localparam logic [7:0]  SBCB_RST_FMT  = 8'h00;
  localparam logic [7:0]  SBCB_RST_BAUD = 8'h03;
  localparam logic [7:0]  SBCB_RST_ADDR = 8'h01;
  localparam logic [7:0]  SBCB_RST_ROLE = 8'h00;
  localparam logic [15:0] SBCB_CNT_ZERO = 16'h0000;
  localparam logic [15:0] SBCB_CNT_ONE  = 16'h0001;
  localparam logic [7:0]  SBCB_BYTE_ZERO = 8'h00;
  localparam logic [5:0]  SBCB_EV_ZERO  = 6'h00;

  // event bit positions in status and mask
  localparam int unsigned SBCB_EV_SENT    = 0;
  localparam int unsigned SBCB_EV_GOOD    = 1;
  localparam int unsigned SBCB_EV_TIMEOUT = 2;
  localparam int unsigned SBCB_EV_ERRREP  = 3;
  localparam int unsigned SBCB_EV_SLV_RX  = 4;
  localparam int unsigned SBCB_EV_SLV_TX  = 5;

  // last error type encoding
  typedef enum logic [7:0] {
    SBCB_ERR_NONE    = 8'h00,
    SBCB_ERR_TIMEOUT = 8'h04,
    SBCB_ERR_REPLY   = 8'h05
  } sbcb_err_t;

endpackage

// ### rtl/sbcb_top.sv
// Purpose: status and configuration bank for the two serial ports
// Assumes: frame engine delivers one-cycle event pulses on clk
// Notes:   read data stand one cycle after the read strobe only
`timescale 1ns/1ps

module sbcb_top
  import sbcb_pkg::*;
(
  // clock and reset
  input  logic                          clk,
  input  logic                          sys_rst,
  // register port
  input  logic [sbcb_pkg::SBCB_AW-1:0]  reg_addr,
  input  logic [sbcb_pkg::SBCB_DW-1:0]  reg_wdata,
  input  logic                          reg_wr,
  input  logic                          reg_rd,
  output logic [sbcb_pkg::SBCB_DW-1:0]  reg_rdata,
  // master events from the frame engine
  input  logic                          evt_req_sent,
  input  logic                          evt_good_reply,
  input  logic                          evt_timeout,
  input  logic                          evt_err_reply,
  input  logic [sbcb_pkg::SBCB_BW-1:0]  evt_slave_addr,
  input  logic [sbcb_pkg::SBCB_BW-1:0]  evt_err_code,
  // slave events from the frame engine
  input  logic                          evt_slave_rx,
  input  logic                          evt_slave_tx,
  input  logic [sbcb_pkg::SBCB_BW-1:0]  rx_frame_addr,
  // configuration to the ports
  output logic [sbcb_pkg::SBCB_BW-1:0]  rs232_fmt,
  output logic [sbcb_pkg::SBCB_BW-1:0]  rs232_baud,
  output logic [sbcb_pkg::SBCB_BW-1:0]  rs485_fmt,
  output logic [sbcb_pkg::SBCB_BW-1:0]  rs485_baud,
  output logic [sbcb_pkg::SBCB_BW-1:0]  rs485_slave_addr,
  output logic                          rs485_master_role,
  output logic                          master_off,
  output logic                          slave_addr_hit,
  // interrupt
  output logic                          irq
);
  import sbcb_pkg::*;

  // configuration state
  logic [7:0]  fmt232_q, fmt232_d, baud232_q, baud232_d;
  logic [7:0]  fmt485_q, fmt485_d, baud485_q, baud485_d;
  logic [7:0]  addr_q, addr_d, role_q, role_d;
  logic        off_req_q, off_req_d;
  logic        dis_q, dis_d;
  // master and slave statistics
  logic [15:0] sent_q, sent_d, good_q, good_d, tout_q, tout_d, erep_q, erep_d;
  logic [15:0] srx_q, srx_d, stx_q, stx_d;
  logic [7:0]  lslave_q, lslave_d, lcode_q, lcode_d;
  sbcb_err_t   ltype_q, ltype_d;
  logic        hit_q, hit_d;
  // interrupt and read state
  logic [5:0]  sts_q, sts_d, mask_q, mask_d;
  logic [5:0]  evt_v;
  logic        irq_q, irq_d;
  logic [15:0] rdata_q, rdata_d;
  logic        wr_fmt_ok, wr_baud_ok, mst_on, rx_hit;

  // write value checks
  assign wr_fmt_ok  = (reg_wdata[7:0] <= SBCB_FMT_MAX) &&
                      (reg_wdata[7:0] != SBCB_FMT_RESERVED);
  assign wr_baud_ok = (reg_wdata[7:0] <= SBCB_BAUD_MAX);

  // configuration next values
  always_comb begin
    fmt232_d  = fmt232_q;
    baud232_d = baud232_q;
    fmt485_d  = fmt485_q;
    baud485_d = baud485_q;
    addr_d    = addr_q;
    role_d    = role_q;
    off_req_d = off_req_q;
    if (reg_wr) begin
      case (reg_addr)
        SBCB_OFS_RS232_FMT: begin
          if (wr_fmt_ok) fmt232_d = reg_wdata[7:0];
        end
        SBCB_OFS_RS232_BAUD: begin
          if (wr_baud_ok) baud232_d = reg_wdata[7:0];
        end
        SBCB_OFS_RS485_FMT: begin
          if (wr_fmt_ok) fmt485_d = reg_wdata[7:0];
        end
        SBCB_OFS_RS485_BAUD: begin
          if (wr_baud_ok) baud485_d = reg_wdata[7:0];
        end
        SBCB_OFS_RS485_ADDR: begin
          if (reg_wdata[7:0] >= SBCB_ADDR_MIN && reg_wdata[7:0] <= SBCB_ADDR_MAX) begin
            addr_d = reg_wdata[7:0];
          end
        end
        SBCB_OFS_RS485_ROLE: begin
          if (reg_wdata[7:0] == SBCB_ROLE_SLAVE || reg_wdata[7:0] == SBCB_ROLE_MASTER) begin
            role_d = reg_wdata[7:0];
          end
        end
        SBCB_OFS_MASTER: begin
          if (reg_wdata == SBCB_CTL_OFF) off_req_d = 1'b1;
          else if (reg_wdata == SBCB_CTL_RUN) off_req_d = 1'b0;
        end
        default: begin
          // reserved and read-only offsets drop writes
          off_req_d = off_req_q;
        end
      endcase
    end
    // disabled on request or while the port is a slave
    dis_d = off_req_d || (role_d == SBCB_ROLE_SLAVE);
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fmt232_q  <= SBCB_RST_FMT;
      baud232_q <= SBCB_RST_BAUD;
      fmt485_q  <= SBCB_RST_FMT;
      baud485_q <= SBCB_RST_BAUD;
      addr_q    <= SBCB_RST_ADDR;
      role_q    <= SBCB_RST_ROLE;
      off_req_q <= 1'b0;
      dis_q     <= 1'b1;
    end else begin
      fmt232_q  <= fmt232_d;
      baud232_q <= baud232_d;
      fmt485_q  <= fmt485_d;
      baud485_q <= baud485_d;
      addr_q    <= addr_d;
      role_q    <= role_d;
      off_req_q <= off_req_d;
      dis_q     <= dis_d;
    end
  end

  // statistics next values
  assign mst_on = !dis_d;
  assign rx_hit = (rx_frame_addr == addr_q);
  always_comb begin
    sent_d   = sent_q;
    good_d   = good_q;
    tout_d   = tout_q;
    erep_d   = erep_q;
    lslave_d = lslave_q;
    ltype_d  = ltype_q;
    lcode_d  = lcode_q;
    srx_d    = srx_q;
    stx_d    = stx_q;
    hit_d    = 1'b0;
    if (!mst_on) begin
      // disabled master holds all master statistics at zero
      sent_d   = SBCB_CNT_ZERO;
      good_d   = SBCB_CNT_ZERO;
      tout_d   = SBCB_CNT_ZERO;
      erep_d   = SBCB_CNT_ZERO;
      lslave_d = SBCB_BYTE_ZERO;
      ltype_d  = SBCB_ERR_NONE;
      lcode_d  = SBCB_BYTE_ZERO;
    end else begin
      // 16-bit sums wrap to zero past 65535
      if (evt_req_sent) sent_d = sent_q + SBCB_CNT_ONE;
      if (evt_good_reply) good_d = good_q + SBCB_CNT_ONE;
      if (evt_timeout) begin
        tout_d   = tout_q + SBCB_CNT_ONE;
        lslave_d = evt_slave_addr;
        ltype_d  = SBCB_ERR_TIMEOUT;
        lcode_d  = SBCB_BYTE_ZERO;
      end
      // error reply wins the last error bytes on a tie
      if (evt_err_reply) begin
        erep_d   = erep_q + SBCB_CNT_ONE;
        lslave_d = evt_slave_addr;
        ltype_d  = SBCB_ERR_REPLY;
        lcode_d  = evt_err_code;
      end
    end
    // slave traffic counts only in slave role
    if (role_q == SBCB_ROLE_SLAVE) begin
      if (evt_slave_rx && rx_hit) begin
        srx_d = srx_q + SBCB_CNT_ONE;
        hit_d = 1'b1;
      end
      if (evt_slave_tx) stx_d = stx_q + SBCB_CNT_ONE;
    end
  end

  // statistics registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sent_q   <= SBCB_CNT_ZERO;
      good_q   <= SBCB_CNT_ZERO;
      tout_q   <= SBCB_CNT_ZERO;
      erep_q   <= SBCB_CNT_ZERO;
      lslave_q <= SBCB_BYTE_ZERO;
      ltype_q  <= SBCB_ERR_NONE;
      lcode_q  <= SBCB_BYTE_ZERO;
      srx_q    <= SBCB_CNT_ZERO;
      stx_q    <= SBCB_CNT_ZERO;
      hit_q    <= 1'b0;
    end else begin
      sent_q   <= sent_d;
      good_q   <= good_d;
      tout_q   <= tout_d;
      erep_q   <= erep_d;
      lslave_q <= lslave_d;
      ltype_q  <= ltype_d;
      lcode_q  <= lcode_d;
      srx_q    <= srx_d;
      stx_q    <= stx_d;
      hit_q    <= hit_d;
    end
  end

  // events that actually moved a counter
  always_comb begin
    evt_v = SBCB_EV_ZERO;
    evt_v[SBCB_EV_SENT]    = mst_on && evt_req_sent;
    evt_v[SBCB_EV_GOOD]    = mst_on && evt_good_reply;
    evt_v[SBCB_EV_TIMEOUT] = mst_on && evt_timeout;
    evt_v[SBCB_EV_ERRREP]  = mst_on && evt_err_reply;
    evt_v[SBCB_EV_SLV_RX]  = (role_q == SBCB_ROLE_SLAVE) && evt_slave_rx && rx_hit;
    evt_v[SBCB_EV_SLV_TX]  = (role_q == SBCB_ROLE_SLAVE) && evt_slave_tx;
  end

  // interrupt and read data next values
  always_comb begin
    mask_d  = mask_q;
    sts_d   = sts_q;
    rdata_d = SBCB_CNT_ZERO;
    if (reg_wr && reg_addr == SBCB_OFS_IRQ_MASK) mask_d = reg_wdata[5:0];
    if (reg_wr && reg_addr == SBCB_OFS_IRQ_STS) sts_d = sts_q & ~reg_wdata[5:0];
    // a new event beats a clear in the same cycle
    sts_d = sts_d | evt_v;
    irq_d = |(sts_d & mask_d);
    if (reg_rd) begin
      case (reg_addr)
        SBCB_OFS_RS232_FMT:   rdata_d = {SBCB_BYTE_ZERO, fmt232_q};
        SBCB_OFS_RS232_BAUD:  rdata_d = {SBCB_BYTE_ZERO, baud232_q};
        SBCB_OFS_RS485_ADDR:  rdata_d = {SBCB_BYTE_ZERO, addr_q};
        SBCB_OFS_RS485_ROLE:  rdata_d = {SBCB_BYTE_ZERO, role_q};
        SBCB_OFS_RS485_FMT:   rdata_d = {SBCB_BYTE_ZERO, fmt485_q};
        SBCB_OFS_RS485_BAUD:  rdata_d = {SBCB_BYTE_ZERO, baud485_q};
        SBCB_OFS_MASTER: begin
          rdata_d = dis_q ? {SBCB_BYTE_ZERO, SBCB_STATE_OFF}
                          : {SBCB_BYTE_ZERO, SBCB_STATE_NORMAL};
        end
        SBCB_OFS_SENT:        rdata_d = sent_q;
        SBCB_OFS_GOOD:        rdata_d = good_q;
        SBCB_OFS_TIMEOUT:     rdata_d = tout_q;
        SBCB_OFS_ERRREP:      rdata_d = erep_q;
        SBCB_OFS_LAST_SLAVE:  rdata_d = {SBCB_BYTE_ZERO, lslave_q};
        SBCB_OFS_LAST_TYPE:   rdata_d = {SBCB_BYTE_ZERO, ltype_q};
        SBCB_OFS_LAST_CODE:   rdata_d = {SBCB_BYTE_ZERO, lcode_q};
        SBCB_OFS_SLV_RX:      rdata_d = srx_q;
        SBCB_OFS_SLV_TX:      rdata_d = stx_q;
        SBCB_OFS_IRQ_STS:     rdata_d = {10'h000, sts_q};
        SBCB_OFS_IRQ_MASK:    rdata_d = {10'h000, mask_q};
        default:              rdata_d = SBCB_CNT_ZERO;
      endcase
    end
  end

  // interrupt and read data registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q  <= SBCB_EV_ZERO;
      sts_q   <= SBCB_EV_ZERO;
      irq_q   <= 1'b0;
      rdata_q <= SBCB_CNT_ZERO;
    end else begin
      mask_q  <= mask_d;
      sts_q   <= sts_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata         = rdata_q;
  assign rs232_fmt         = fmt232_q;
  assign rs232_baud        = baud232_q;
  assign rs485_fmt         = fmt485_q;
  assign rs485_baud        = baud485_q;
  assign rs485_slave_addr  = addr_q;
  assign rs485_master_role = role_q[0];
  assign master_off        = dis_q;
  assign slave_addr_hit    = hit_q;
  assign irq               = irq_q;

  // checks
  sequence s_off_write;
    reg_wr && reg_addr == SBCB_OFS_MASTER && reg_wdata == SBCB_CTL_OFF;
  endsequence
  sequence s_all_clear;
    sent_q == SBCB_CNT_ZERO && good_q == SBCB_CNT_ZERO && tout_q == SBCB_CNT_ZERO
      && erep_q == SBCB_CNT_ZERO && lslave_q == SBCB_BYTE_ZERO;
  endsequence
  sequence s_read_master;
    reg_rd && reg_addr == SBCB_OFS_MASTER;
  endsequence

  chk_off_clears_all: assert property (@(posedge clk) disable iff (sys_rst)
    s_off_write |=> dis_q ##0 s_all_clear ##1 s_all_clear)
    else $error("disable did not clear master statistics");
  chk_state_readback: assert property (@(posedge clk) disable iff (sys_rst)
    s_read_master |=> reg_rdata == {SBCB_BYTE_ZERO, $past(dis_q) ? SBCB_STATE_OFF
                                                             : SBCB_STATE_NORMAL})
    else $error("master state read wrong");
  chk_slave_role_off: assert property (@(posedge clk) disable iff (sys_rst)
    role_q == SBCB_ROLE_SLAVE |-> dis_q)
    else $error("slave role not reported as disabled master");
  chk_sent_count: assert property (@(posedge clk) disable iff (sys_rst)
    !dis_d && evt_req_sent |=> sent_q == $past(sent_q) + SBCB_CNT_ONE)
    else $error("sent counter did not step");
  chk_good_count: assert property (@(posedge clk) disable iff (sys_rst)
    !dis_d && !evt_good_reply |=> good_q == $past(good_q))
    else $error("good counter moved without event");
  chk_timeout_type: assert property (@(posedge clk) disable iff (sys_rst)
    !dis_d && evt_timeout && !evt_err_reply |=> ltype_q == SBCB_ERR_TIMEOUT
      && tout_q == $past(tout_q) + SBCB_CNT_ONE && lcode_q == SBCB_BYTE_ZERO)
    else $error("timeout not recorded");
  chk_err_capture: assert property (@(posedge clk) disable iff (sys_rst)
    !dis_d && evt_err_reply |=> ltype_q == SBCB_ERR_REPLY
      && lcode_q == $past(evt_err_code) && lslave_q == $past(evt_slave_addr))
    else $error("error reply not captured");
  chk_rx_master_hold: assert property (@(posedge clk) disable iff (sys_rst)
    role_q == SBCB_ROLE_MASTER |=> $stable(srx_q) && $stable(stx_q))
    else $error("slave counters moved in master role");
  chk_addr_legal: assert property (@(posedge clk) disable iff (sys_rst)
    addr_q >= SBCB_ADDR_MIN && addr_q <= SBCB_ADDR_MAX)
    else $error("slave address out of range");
  chk_good_step: assert property (@(posedge clk) disable iff (sys_rst)
    !dis_d && evt_good_reply |=> good_q == $past(good_q) + SBCB_CNT_ONE)
    else $error("good counter did not step");
  chk_err_step: assert property (@(posedge clk) disable iff (sys_rst)
    !dis_d && evt_err_reply |=> erep_q == $past(erep_q) + SBCB_CNT_ONE)
    else $error("error reply counter did not step");
  chk_rx_counted: assert property (@(posedge clk) disable iff (sys_rst)
    role_q == SBCB_ROLE_SLAVE && evt_slave_rx && rx_hit |=> srx_q == $past(srx_q) + SBCB_CNT_ONE)
    else $error("slave rx frame not counted");
  chk_baud_legal: assert property (@(posedge clk) disable iff (sys_rst)
    baud485_q <= SBCB_BAUD_MAX && baud232_q <= SBCB_BAUD_MAX)
    else $error("baud select holds an illegal code");
  chk_fmt_legal: assert property (@(posedge clk) disable iff (sys_rst)
    fmt485_q != SBCB_FMT_RESERVED && fmt485_q <= SBCB_FMT_MAX
      && fmt232_q != SBCB_FMT_RESERVED && fmt232_q <= SBCB_FMT_MAX)
    else $error("byte format holds an illegal code");
  chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    irq == |(sts_q & mask_q))
    else $error("interrupt level mismatch");

endmodule // sbcb_top
